// >>> hdl/tcl_consts.svh
// What this block does
// - opcode 20e loads accumulator into register one
// - opcode 20f loads accumulator into register two
// - opcode 210 loads accumulator into register three
// - opcode 211 loads accumulator into register four
// - opcode 212 loads accumulator into register five
// - opcode 213 loads accumulator into register six
// - one word, one cycle, carry kept, no skip
//
// Purpose: offsets, field positions, reset values and opcodes of the timer control load decoder
// Assumes: included by bare name from the package and the modules
// Notes: definitions only
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH

// ==========================================================
// opcodes
`define TCL_OP_LOAD_ONE 10'h20e
`define TCL_OP_LOAD_TWO 10'h20f
`define TCL_OP_LOAD_THREE 10'h210
`define TCL_OP_LOAD_FOUR 10'h211
`define TCL_OP_LOAD_FIVE 10'h212
`define TCL_OP_LOAD_SIX 10'h213
`define TCL_NUM_REGS 6

// ==========================================================
// register offsets
`define TCL_OFF_CTRL 12'h000
`define TCL_OFF_STATUS 12'h004
`define TCL_OFF_VALUES 12'h008
`define TCL_OFF_OPCODE 12'h00c
`define TCL_OFF_SWLOAD 12'h010

// ==========================================================
// field positions
`define TCL_CTRL_ENABLE_BIT 0
`define TCL_CTRL_CLRCNT_BIT 1
`define TCL_STAT_IDX_LSB 0
`define TCL_STAT_CNT_LSB 8
`define TCL_SW_IDX_LSB 0
`define TCL_SW_VAL_LSB 4

// ==========================================================
// reset values
`define TCL_CTRL_ENABLE_RESET 1'b1
`define TCL_TMR_RESET 4'h0
`define TCL_IDX_NONE 3'h0

`endif

// >>> hdl/tcl_pkg.sv
// Purpose: shared types of the timer control load decoder
// Assumes: tcl_consts.svh supplies the numbers
// Notes: types only
`include "tcl_consts.svh"

package tcl_pkg;

    // ==========================================================
    // carriers
    typedef logic [3:0] tcl_nibble_t;
    typedef tcl_nibble_t [`TCL_NUM_REGS-1:0] tcl_timer_bank_t;

    typedef struct packed {
        logic valid;
        logic [9:0] opcode;
        tcl_nibble_t acc;
        logic carry;
    } tcl_fetch_s;

    typedef struct packed {
        logic carry;
        logic carry_we;
        logic acc_we;
        logic skip_next;
    } tcl_core_s;

    // ==========================================================
    // module state
    typedef struct packed {
        logic enable;
        tcl_timer_bank_t timer_ctrl;
        logic [`TCL_NUM_REGS-1:0] load_strobe;
        logic [2:0] last_idx;
        logic [9:0] last_opcode;
        logic [15:0] load_count;
        logic [31:0] prdata;
        logic pslverr;
        tcl_core_s core;
    } tcl_state_s;

endpackage : tcl_pkg

// >>> hdl/tcl_opdec.sv
// Purpose: combinational match of the six timer control load opcodes
// Assumes: opcode is stable for the whole machine cycle
// Notes: one-hot result plus a 1-based index
`timescale 1ns/100ps
`include "tcl_consts.svh"

module tcl_opdec (
    // fetched word
    input wire logic valid,
    input wire logic [9:0] opcode,
    // result
    output logic [`TCL_NUM_REGS-1:0] hit,
    output logic [2:0] idx
);
    import tcl_pkg::*;

    localparam logic [9:0] OPS [`TCL_NUM_REGS] = '{
        `TCL_OP_LOAD_ONE,
        `TCL_OP_LOAD_TWO,
        `TCL_OP_LOAD_THREE,
        `TCL_OP_LOAD_FOUR,
        `TCL_OP_LOAD_FIVE,
        `TCL_OP_LOAD_SIX
    };

    // ==========================================================
    // matchers
    genvar gi;
    generate
        for (gi = 0; gi < `TCL_NUM_REGS; gi++) begin : g_match
            assign hit[gi] = valid && (opcode == OPS[gi]);
        end
    endgenerate

    always_comb begin
        idx = `TCL_IDX_NONE;
        for (int i = 0; i < `TCL_NUM_REGS; i++) begin
            if (hit[i]) begin
                idx = 3'(i + 1);
            end
        end
    end

endmodule : tcl_opdec

// >>> hdl/tcl_timer_ctrl_load.sv
// Purpose: decode of the accumulator-to-timer-control transfers, with an APB view
// Assumes: fetch carrier is on clk and holds one word per machine cycle
// Notes: zero wait state APB slave; decoded loads win over software loads
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
`include "tcl_consts.svh"

module tcl_timer_ctrl_load (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // instruction fetch side
    input wire tcl_pkg::tcl_fetch_s fetch,
    // core side effects
    output tcl_pkg::tcl_core_s core,
    // timer peripheral side
    output tcl_pkg::tcl_timer_bank_t timer_ctrl,
    output logic [`TCL_NUM_REGS-1:0] load_strobe,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import tcl_pkg::*;

    // ==========================================================
    // address decode
    function automatic logic addr_known(input logic [11:0] a);
        case (a)
            `TCL_OFF_CTRL,
            `TCL_OFF_STATUS,
            `TCL_OFF_VALUES,
            `TCL_OFF_OPCODE,
            `TCL_OFF_SWLOAD: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction : addr_known

    function automatic logic addr_writable(input logic [11:0] a);
        case (a)
            `TCL_OFF_CTRL,
            `TCL_OFF_SWLOAD: addr_writable = 1'b1;
            default: addr_writable = 1'b0;
        endcase
    endfunction : addr_writable

    // ==========================================================
    // opcode match
    logic [`TCL_NUM_REGS-1:0] op_hit;
    logic [2:0] op_idx;

    tcl_opdec i_tcl_opdec (
        .valid(fetch.valid),
        .opcode(fetch.opcode),
        .hit(op_hit),
        .idx(op_idx)
    );

    // ==========================================================
    // state
    tcl_state_s s_reg;
    tcl_state_s s_next;

    logic setup_phase;
    logic access_phase;
    logic wr_take;
    logic [`TCL_NUM_REGS-1:0] dec_load;
    logic [`TCL_NUM_REGS-1:0] sw_load;
    logic [2:0] sw_idx;
    tcl_nibble_t sw_val;
    logic any_dec;
    logic clr_count;
    logic [31:0] rd_word;

    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    // writes land on the access edge, as the bus requires
    assign wr_take = access_phase && pwrite && addr_writable(paddr);
    assign sw_idx = pwdata[`TCL_SW_IDX_LSB +: 3];
    assign sw_val = pwdata[`TCL_SW_VAL_LSB +: 4];
    assign any_dec = |dec_load;

    // decoding is gated by the enable bit; a disabled decoder leaves the bank alone
    always_comb begin
        for (int i = 0; i < `TCL_NUM_REGS; i++) begin
            dec_load[i] = s_reg.enable && op_hit[i];
        end
    end

    // software load of one register, only bytes 0 lanes carry index and value
    always_comb begin
        for (int i = 0; i < `TCL_NUM_REGS; i++) begin
            sw_load[i] = wr_take && (paddr == `TCL_OFF_SWLOAD) && pstrb[0] && (sw_idx == 3'(i + 1));
        end
    end

    assign clr_count = wr_take && (paddr == `TCL_OFF_CTRL) && pstrb[0] && pwdata[`TCL_CTRL_CLRCNT_BIT];

    // ==========================================================
    // read mux, sampled in the setup cycle so prdata is a flop in the access cycle
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            `TCL_OFF_CTRL: begin
                rd_word[`TCL_CTRL_ENABLE_BIT] = s_reg.enable;
            end
            `TCL_OFF_STATUS: begin
                rd_word[`TCL_STAT_IDX_LSB +: 3] = s_reg.last_idx;
                rd_word[`TCL_STAT_CNT_LSB +: 16] = s_reg.load_count;
            end
            `TCL_OFF_VALUES: begin
                rd_word[23:0] = s_reg.timer_ctrl;
            end
            `TCL_OFF_OPCODE: begin
                rd_word[9:0] = s_reg.last_opcode;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.load_strobe = '0;

        // every opcode here is one word, one cycle: no skip, carry passed, carry not written
        s_next.core.carry = fetch.carry;
        s_next.core.carry_we = 1'b0;
        s_next.core.skip_next = 1'b0;
        // the accumulator is only a source here
        s_next.core.acc_we = 1'b0;

        // control register
        if (wr_take && (paddr == `TCL_OFF_CTRL) && pstrb[0]) begin
            s_next.enable = pwdata[`TCL_CTRL_ENABLE_BIT];
        end

        // software loads first so a same-cycle decoded load overrides them
        for (int i = 0; i < `TCL_NUM_REGS; i++) begin
            if (sw_load[i]) begin
                s_next.timer_ctrl[i] = sw_val;
                s_next.load_strobe[i] = 1'b1;
            end
        end

        // decoded transfers, whole nibble in the same cycle, other registers untouched
        if (dec_load[0]) begin
            s_next.timer_ctrl[0] = fetch.acc;
        end
        if (dec_load[1]) begin
            s_next.timer_ctrl[1] = fetch.acc;
        end
        if (dec_load[2]) begin
            s_next.timer_ctrl[2] = fetch.acc;
        end
        if (dec_load[3]) begin
            s_next.timer_ctrl[3] = fetch.acc;
        end
        if (dec_load[4]) begin
            s_next.timer_ctrl[4] = fetch.acc;
        end
        if (dec_load[5]) begin
            s_next.timer_ctrl[5] = fetch.acc;
        end
        if (any_dec) begin
            s_next.load_strobe = s_next.load_strobe | dec_load;
            s_next.last_idx = op_idx;
            s_next.last_opcode = fetch.opcode;
        end

        // counter: a load in the clearing cycle still counts
        if (clr_count) begin
            s_next.load_count = any_dec ? 16'h0001 : 16'h0000;
        end else if (any_dec) begin
            s_next.load_count = s_reg.load_count + 16'h0001;
        end

        // bus answer
        if (setup_phase) begin
            s_next.prdata = pwrite ? 32'h0000_0000 : rd_word;
            s_next.pslverr = !addr_known(paddr) || (pwrite && !addr_writable(paddr));
        end else if (!psel) begin
            s_next.prdata = 32'h0000_0000;
            s_next.pslverr = 1'b0;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg.enable <= `TCL_CTRL_ENABLE_RESET;
            for (int i = 0; i < `TCL_NUM_REGS; i++) begin
                s_reg.timer_ctrl[i] <= `TCL_TMR_RESET;
            end
            s_reg.load_strobe <= '0;
            s_reg.last_idx <= `TCL_IDX_NONE;
            s_reg.last_opcode <= 10'h000;
            s_reg.load_count <= 16'h0000;
            s_reg.prdata <= 32'h0000_0000;
            s_reg.pslverr <= 1'b0;
            s_reg.core <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs
    assign timer_ctrl = s_reg.timer_ctrl;
    assign load_strobe = s_reg.load_strobe;
    assign core = s_reg.core;
    assign prdata = s_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = access_phase && s_reg.pslverr;

endmodule : tcl_timer_ctrl_load

// >>> testbench/tcl_timer_ctrl_load_asserts.sv
// Purpose: property checks for the timer control load decoder
// Assumes: decode enable only changes through apb writes to the control word
// Notes: bound to tcl_timer_ctrl_load
`timescale 1ns/100ps
`include "tcl_consts.svh"

module tcl_asserts
    import tcl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // fetch and core
    input wire tcl_pkg::tcl_fetch_s fetch,
    input wire tcl_pkg::tcl_core_s core,
    // timer side
    input wire tcl_pkg::tcl_timer_bank_t timer_ctrl,
    input wire logic [`TCL_NUM_REGS-1:0] load_strobe,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb
);
    // ==========================================================
    // shadow of the decode enable
    logic en_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_reg <= 1'b1;
        end else if (psel && penable && pwrite && pstrb[0] && paddr == `TCL_OFF_CTRL) begin
            en_reg <= pwdata[`TCL_CTRL_ENABLE_BIT];
        end
    end

    // ==========================================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_load(logic [9:0] op, int n);
        en_reg && fetch.valid && fetch.opcode == op |=> load_strobe[n] && timer_ctrl[n] == $past(fetch.acc);
    endproperty

    a_load_one: assert property (p_load(`TCL_OP_LOAD_ONE, 0)) else $error("register one not loaded");
    a_load_two: assert property (p_load(`TCL_OP_LOAD_TWO, 1)) else $error("register two not loaded");
    a_load_three: assert property (p_load(`TCL_OP_LOAD_THREE, 2)) else $error("register three not loaded");
    a_load_four: assert property (p_load(`TCL_OP_LOAD_FOUR, 3)) else $error("register four not loaded");
    a_load_five: assert property (p_load(`TCL_OP_LOAD_FIVE, 4)) else $error("register five not loaded");
    a_load_six: assert property (p_load(`TCL_OP_LOAD_SIX, 5)) else $error("register six not loaded");
    a_others_kept: assert property (fetch.valid && fetch.opcode == `TCL_OP_LOAD_ONE && !(psel && pwrite)
        |=> timer_ctrl[5:1] == $past(timer_ctrl[5:1])) else $error("other register changed");
    a_carry_kept: assert property (1'b1 |=> core.carry == $past(fetch.carry)) else $error("carry changed");
    a_flags_quiet: assert property (!core.carry_we && !core.skip_next) else $error("carry write or skip");
    a_acc_kept: assert property (!core.acc_we) else $error("accumulator written");

    c_load_six: cover property (fetch.valid && fetch.opcode == `TCL_OP_LOAD_SIX ##1 load_strobe[5]);
    c_back_to_back: cover property (load_strobe[0] ##1 load_strobe[1]);
    c_disabled: cover property (!en_reg && fetch.valid);
endmodule : tcl_asserts

bind tcl_timer_ctrl_load tcl_asserts i_tcl_asserts (.clk(clk), .reset_n(reset_n), .fetch(fetch), .core(core),
    .timer_ctrl(timer_ctrl), .load_strobe(load_strobe), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

// >>> testbench/tcl_timer_ctrl_load_tb.sv
// Purpose: self-checking bench for the timer control load decoder
// Assumes: zero wait state apb, loads seen one cycle after the fetch edge
// Notes: fetch words are driven back to back
`timescale 1ns/100ps
`include "tcl_consts.svh"

module tcl_timer_ctrl_load_tb;
    import tcl_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    tcl_fetch_s fetch = '0;
    tcl_core_s core;
    tcl_timer_bank_t timer_ctrl;
    tcl_timer_bank_t exp_bank = '0;
    logic [5:0] load_strobe;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    logic [9:0] ops [5] = '{10'h20d, 10'h214, 10'h00e, 10'h30e, 10'h20e};
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    always #2.5 clk = ~clk;

    tcl_timer_ctrl_load i_tcl_timer_ctrl_load (.clk(clk), .reset_n(reset_n), .fetch(fetch), .core(core),
        .timer_ctrl(timer_ctrl), .load_strobe(load_strobe), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ==========================================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one whole apb transfer; read data taken at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end

    // ==========================================================
    // tests
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1 check("reset core", 32'(core), 32'h0);
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            fetch <= '{1'b1, `TCL_OP_LOAD_ONE + 10'(i), 4'(i + 9), i[0]};
            exp_bank[i] = 4'(i + 9);
            @(posedge clk);
            #1 check("strobe", 32'(load_strobe), 32'(1 << i));
            check("bank", 32'(timer_ctrl), 32'(exp_bank));
            check("carry", 32'(core.carry), 32'(i[0]));
            check("flags", {core.carry_we, core.acc_we, core.skip_next}, 32'h0);
        end
        // neighbours of the opcode range and an idle word must be ignored
        for (int i = 0; i < 5; i++) begin
            fetch <= '{i < 4, ops[i], 4'h3, 1'b0};
            @(posedge clk);
            #1 check("refused strobe", 32'(load_strobe), 32'h0);
            check("refused bank", 32'(timer_ctrl), 32'(exp_bank));
        end
        fetch <= '0;
        apb(1'b0, `TCL_OFF_STATUS, 32'h0);
        check("status", rd, 32'h606);
        check("status ok", {pready, er}, 32'h2);
        apb(1'b0, `TCL_OFF_OPCODE, 32'h0);
        check("opcode", rd, 32'h213);
        apb(1'b1, `TCL_OFF_STATUS, 32'hff);
        check("ro error", 32'(er), 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", {rd[30:0], er}, 32'h1);
        // value differs from what the decoded load left, so a lost write shows
        apb(1'b1, `TCL_OFF_SWLOAD, 32'h52);
        exp_bank[1] = 4'h5;
        apb(1'b0, `TCL_OFF_VALUES, 32'h0);
        check("values", rd, 32'(exp_bank));
        apb(1'b1, `TCL_OFF_CTRL, 32'h3);
        apb(1'b0, `TCL_OFF_STATUS, 32'h0);
        check("cleared", rd, 32'h6);
        // a write without byte lane 0 must leave decoding enabled
        pstrb <= 4'he;
        apb(1'b1, `TCL_OFF_CTRL, 32'h0);
        pstrb <= 4'hf;
        apb(1'b0, `TCL_OFF_CTRL, 32'h0);
        check("lane gated", rd, 32'h1);
        // decoding switched off must leave the bank alone
        apb(1'b1, `TCL_OFF_CTRL, 32'h0);
        fetch <= '{1'b1, `TCL_OP_LOAD_ONE, 4'hf, 1'b0};
        @(posedge clk);
        fetch <= '0;
        @(posedge clk);
        #1 check("disabled", 32'(timer_ctrl), 32'(exp_bank));
        apb(1'b1, `TCL_OFF_CTRL, 32'h1);
        wrap_up();
    end
endmodule : tcl_timer_ctrl_load_tb
